// File: hw/spie_params.svh
// Offsets, field positions, reset values and timing counts of the serial-port event logic.
`ifndef SPIE_PARAMS_SVH
`define SPIE_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPIE_OFS_ENABLE     3'h0
`define SPIE_OFS_IDENTITY   3'h1
`define SPIE_OFS_FIFOCTL    3'h2
`define SPIE_OFS_LINECTL    3'h3
`define SPIE_OFS_LINESTAT   3'h4
`define SPIE_OFS_PWREMU     3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPIE_EN_RXREADY     0
`define SPIE_EN_TXEMPTY     1
`define SPIE_EN_LINESTAT    2
`define SPIE_EN_TIMEOUT     3
`define SPIE_ID_PENDN       0
`define SPIE_ID_CODE_LO     1
`define SPIE_ID_CODE_HI     3
`define SPIE_FC_ENABLE      0
`define SPIE_FC_TRIG_LO     6
`define SPIE_FC_TRIG_HI     7
`define SPIE_LC_WLEN_LO     0
`define SPIE_LC_WLEN_HI     1
`define SPIE_LS_AVAIL       0
`define SPIE_LS_OVERRUN     1
`define SPIE_LS_PARITY      2
`define SPIE_LS_FRAMING     3
`define SPIE_LS_BREAK       4
`define SPIE_LS_TXEMPTY     5
`define SPIE_PWR_PORTRSTN   0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPIE_RST_ENABLE     4'h0
`define SPIE_RST_FIFOCTL    8'h00
`define SPIE_RST_LINECTL    2'h0
`define SPIE_RST_PORTRSTN   1'b0

// ----------------------------------------------------------------
// Timing counts and receive FIFO trigger levels
// ----------------------------------------------------------------
`define SPIE_BCLK_PER_BIT   16
`define SPIE_CHAR_TIMES     4
`define SPIE_BASE_BITS      8
`define SPIE_TRIG_L0        5'h01
`define SPIE_TRIG_L1        5'h04
`define SPIE_TRIG_L2        5'h08
`define SPIE_TRIG_L3        5'h0e

`endif

// File: hw/spie_pkg.sv
// Types shared by the serial-port event logic.
`default_nettype none

package spie_pkg;

    typedef enum logic [2:0] {
        SRC_NONE     = 3'b000,
        SRC_TXEMPTY  = 3'b001,
        SRC_RXREADY  = 3'b010,
        SRC_LINESTAT = 3'b011,
        SRC_TIMEOUT  = 3'b110
    } spie_src_type;

    typedef enum logic [2:0] {
        TM_IDLE = 3'b001,
        TM_RUN  = 3'b010,
        TM_DONE = 3'b100
    } spie_tmstate_type;

endpackage : spie_pkg

`default_nettype wire

// File: hw/spie_arbiter.sv
// Fixed-priority pick of one interrupt source code from a request vector.
`default_nettype none
`include "spie_params.svh"

module spie_arbiter
    import spie_pkg::*;
(
    input  wire logic [3:0]   reqVec,   // Requests by enable-bit position
    output spie_src_type      winCode,  // Code of the winning source
    output logic              winAny    // Some request present
);

    // Line status beats both receive sources, which beat transmit empty.
    always_comb begin
        winAny  = |reqVec;
        winCode = SRC_NONE;
        if (reqVec[`SPIE_EN_LINESTAT]) begin
            winCode = SRC_LINESTAT;
        end else if (reqVec[`SPIE_EN_TIMEOUT]) begin
            winCode = SRC_TIMEOUT;
        end else if (reqVec[`SPIE_EN_RXREADY]) begin
            winCode = SRC_RXREADY;
        end else if (reqVec[`SPIE_EN_TXEMPTY]) begin
            winCode = SRC_TXEMPTY;
        end
    end

endmodule : spie_arbiter

`default_nettype wire

// File: hw/spie_char_timer.sv
// Four-character-time receive idle timer counted in baud clock ticks.
`default_nettype none
`include "spie_params.svh"

module spie_char_timer
    import spie_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input  wire logic         sys_clk,   // System clock
    input  wire logic         reset,     // Synchronous reset, active high
    input  wire logic         clear,     // Restart the measurement
    input  wire logic         armed,     // FIFO mode and FIFO not empty
    input  wire logic         bclkTick,  // One pulse per 16x baud clock
    input  wire logic [1:0]   wordLen,   // Word length select
    output logic              expired    // One-cycle pulse at time-out
);

    spie_tmstate_type   state_r;
    logic [CNT_W-1:0]   count_r;
    logic [CNT_W-1:0]   limit;

    // Start, data, parity and stop bits, four times over, sixteen ticks each.
    function automatic logic [CNT_W-1:0] idleLimit(input logic [1:0] wlen);
        return CNT_W'((`SPIE_BASE_BITS + int'(wlen)) * `SPIE_CHAR_TIMES
                      * `SPIE_BCLK_PER_BIT);
    endfunction : idleLimit

    assign limit = idleLimit(wordLen);

    always_ff @(posedge sys_clk) begin
        if (reset || clear || !armed) begin
            state_r <= TM_IDLE;
            count_r <= '0;
        end else begin
            unique case (state_r)
                TM_IDLE: begin
                    state_r <= TM_RUN;
                    count_r <= '0;
                end
                TM_RUN: begin
                    if (bclkTick) begin
                        count_r <= count_r + CNT_W'(1);
                        if (count_r + CNT_W'(1) >= limit) begin
                            state_r <= TM_DONE;
                        end
                    end
                end
                TM_DONE: begin
                    state_r <= TM_DONE;
                end
            endcase
        end
    end

    // Pulse only on entry to the done state so one idle period yields one event.
    logic doneSeen_r;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            doneSeen_r <= 1'b0;
            expired    <= 1'b0;
        end else begin
            doneSeen_r <= (state_r == TM_DONE);
            expired    <= (state_r == TM_DONE) && !doneSeen_r && !clear && armed;
        end
    end

endmodule : spie_char_timer

`default_nettype wire

// File: hw/spie_top.sv
// Interrupt arbiter, status flags and DMA event generation of the serial port.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`default_nettype none
`include "spie_params.svh"

module spie_top
    import spie_pkg::*;
#(
    parameter int LEVEL_W = 5
) (
    input  wire logic                sys_clk,      // System clock, 200 MHz
    input  wire logic                reset,        // Synchronous reset, active high
    input  wire logic [2:0]          regAddr,      // Register address
    input  wire logic [7:0]          regWdata,     // Register write data
    input  wire logic                regWrite,     // Write strobe
    input  wire logic                regRead,      // Read strobe
    output logic      [7:0]          regRdata,     // Read data, cycle after strobe
    input  wire logic                txEmptyIn,    // Transmit holding or FIFO empty
    input  wire logic                txLoad,       // Character written to transmit side
    input  wire logic [LEVEL_W-1:0]  rxLevel,      // Receive FIFO fill level
    input  wire logic                rxPush,       // Character entered receive FIFO
    input  wire logic                rxPop,        // Character read from receive FIFO
    input  wire logic                overrunEvt,   // Overrun detected
    input  wire logic                parityEvt,    // Parity error detected
    input  wire logic                framingEvt,   // Framing error detected
    input  wire logic                breakEvt,     // Break detected
    input  wire logic                bclkTick,     // 16x baud clock pulse
    output logic                     cpuIrq,       // Interrupt request, active high
    output logic                     rxDmaEvent,   // Receive DMA event pulse
    output logic                     txDmaEvent,   // Transmit DMA event pulse
    output logic                     portResetN    // Port soft reset, active low
);

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic [3:0]          irqEnable_r;
    logic [7:0]          fifoCtl_r;
    logic [1:0]          wordLen_r;
    logic                portSoftResetN_r;
    logic                wrEnable;
    logic                wrFifoCtl;
    logic                wrLineCtl;
    logic                wrPwrEmu;
    logic                lineStatRead;
    logic                fifoMode;
    logic [1:0]          trigSel;

    assign wrEnable     = regWrite && (regAddr == `SPIE_OFS_ENABLE);
    assign wrFifoCtl    = regWrite && (regAddr == `SPIE_OFS_FIFOCTL);
    assign wrLineCtl    = regWrite && (regAddr == `SPIE_OFS_LINECTL);
    assign wrPwrEmu     = regWrite && (regAddr == `SPIE_OFS_PWREMU);
    assign lineStatRead = regRead && (regAddr == `SPIE_OFS_LINESTAT);
    assign fifoMode     = fifoCtl_r[`SPIE_FC_ENABLE];
    assign trigSel      = fifoCtl_r[`SPIE_FC_TRIG_HI:`SPIE_FC_TRIG_LO];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irqEnable_r <= `SPIE_RST_ENABLE;
        end else if (wrEnable) begin
            irqEnable_r <= regWdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fifoCtl_r <= `SPIE_RST_FIFOCTL;
        end else if (wrFifoCtl) begin
            fifoCtl_r <= regWdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wordLen_r <= `SPIE_RST_LINECTL;
        end else if (wrLineCtl) begin
            wordLen_r <= regWdata[`SPIE_LC_WLEN_HI:`SPIE_LC_WLEN_LO];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            portSoftResetN_r <= `SPIE_RST_PORTRSTN;
        end else if (wrPwrEmu) begin
            portSoftResetN_r <= regWdata[`SPIE_PWR_PORTRSTN];
        end
    end

    assign portResetN = portSoftResetN_r;

    // ----------------------------------------------------------------
    // Source conditions
    // ----------------------------------------------------------------
    logic [LEVEL_W-1:0]  trigLevel;
    logic                trigReached;
    logic                rxAvail;
    logic                txEmptyCond;
    logic                rxReadyCond;
    logic                timeout_r;
    logic                timerExpired;
    logic                timerClear;
    logic                timerArmed;

    function automatic logic [LEVEL_W-1:0] trigDecode(input logic [1:0] sel);
        logic [4:0] lvl;
        unique case (sel)
            2'd0: lvl = `SPIE_TRIG_L0;
            2'd1: lvl = `SPIE_TRIG_L1;
            2'd2: lvl = `SPIE_TRIG_L2;
            2'd3: lvl = `SPIE_TRIG_L3;
        endcase
        return LEVEL_W'(lvl);
    endfunction : trigDecode

    assign trigLevel   = trigDecode(trigSel);
    assign rxAvail     = (rxLevel != '0);
    assign trigReached = fifoMode && (rxLevel >= trigLevel);
    // A write in the same cycle already counts as filling the holding side.
    assign txEmptyCond = txEmptyIn && !txLoad;
    assign rxReadyCond = fifoMode ? trigReached : rxAvail;

    // Any FIFO access, port reset or leaving FIFO mode restarts the idle time.
    assign timerClear = rxPush || rxPop || !portSoftResetN_r || !fifoMode;
    assign timerArmed = fifoMode && rxAvail;

    spie_char_timer #(
        .CNT_W    (10)
    ) u_timer (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clear    (timerClear),
        .armed    (timerArmed),
        .bclkTick (bclkTick),
        .wordLen  (wordLen_r),
        .expired  (timerExpired)
    );

    // The clearing access wins here, since an arriving character ends the idle period.
    always_ff @(posedge sys_clk) begin
        if (reset || timerClear || !timerArmed) begin
            timeout_r <= 1'b0;
        end else if (timerExpired) begin
            timeout_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Line status flags
    // ----------------------------------------------------------------
    logic overrun_r;
    logic parity_r;
    logic framing_r;
    logic break_r;
    logic lineStatCond;

    // A detection in the same cycle as the clearing read survives it.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            overrun_r <= 1'b0;
            parity_r  <= 1'b0;
            framing_r <= 1'b0;
            break_r   <= 1'b0;
        end else begin
            overrun_r <= overrunEvt || (overrun_r && !lineStatRead);
            parity_r  <= parityEvt  || (parity_r  && !lineStatRead);
            framing_r <= framingEvt || (framing_r && !lineStatRead);
            break_r   <= breakEvt   || (break_r   && !lineStatRead);
        end
    end

    assign lineStatCond = overrun_r || parity_r || framing_r || break_r;

    // ----------------------------------------------------------------
    // Arbitration and identity recording
    // ----------------------------------------------------------------
    logic [3:0]    condVec;
    logic [3:0]    enabledVec;
    logic [3:0]    enabledPrev_r;
    logic [3:0]    newVec;
    spie_src_type  newCode;
    logic          newAny;
    spie_src_type  srcCode_r;
    logic          pendingN_r;

    always_comb begin
        condVec = '0;
        condVec[`SPIE_EN_RXREADY]  = rxReadyCond;
        condVec[`SPIE_EN_TXEMPTY]  = txEmptyCond;
        condVec[`SPIE_EN_LINESTAT] = lineStatCond;
        condVec[`SPIE_EN_TIMEOUT]  = timeout_r;
    end

    assign enabledVec = condVec & irqEnable_r;
    assign newVec     = enabledVec & ~enabledPrev_r;

    spie_arbiter u_arb (
        .reqVec  (newVec),
        .winCode (newCode),
        .winAny  (newAny)
    );

    function automatic logic codeActive(input spie_src_type code, input logic [3:0] vec);
        logic act;
        unique case (code)
            SRC_NONE:     act = 1'b0;
            SRC_TXEMPTY:  act = vec[`SPIE_EN_TXEMPTY];
            SRC_RXREADY:  act = vec[`SPIE_EN_RXREADY];
            SRC_LINESTAT: act = vec[`SPIE_EN_LINESTAT];
            SRC_TIMEOUT:  act = vec[`SPIE_EN_TIMEOUT];
            default:      act = 1'b0;
        endcase
        return act;
    endfunction : codeActive

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enabledPrev_r <= '0;
        end else begin
            enabledPrev_r <= enabledVec;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            srcCode_r <= SRC_NONE;
        end else if (newAny) begin
            srcCode_r <= newCode;
        end else if (!codeActive(srcCode_r, enabledVec)) begin
            srcCode_r <= SRC_NONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pendingN_r <= 1'b1;
            cpuIrq     <= 1'b0;
        end else begin
            pendingN_r <= ~|enabledVec;
            cpuIrq     <= |enabledVec;
        end
    end

    // ----------------------------------------------------------------
    // DMA events
    // ----------------------------------------------------------------
    logic trigPrev_r;
    logic txEmptyPrev_r;
    logic releaseEvt;

    // Only a 0 to 1 write of the port reset bit counts as a release.
    assign releaseEvt = wrPwrEmu && regWdata[`SPIE_PWR_PORTRSTN] && !portSoftResetN_r;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            trigPrev_r    <= 1'b0;
            txEmptyPrev_r <= 1'b0;
        end else begin
            trigPrev_r    <= trigReached;
            txEmptyPrev_r <= txEmptyIn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rxDmaEvent <= 1'b0;
            txDmaEvent <= 1'b0;
        end else begin
            rxDmaEvent <= fifoMode && portSoftResetN_r
                          && ((trigReached && !trigPrev_r) || timerExpired);
            txDmaEvent <= fifoMode
                          && ((portSoftResetN_r && txEmptyIn && !txEmptyPrev_r)
                              || releaseEvt);
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [7:0] rdMux;

    always_comb begin
        rdMux = 8'h00;
        unique case (regAddr)
            `SPIE_OFS_ENABLE: begin
                rdMux[3:0] = irqEnable_r;
            end
            `SPIE_OFS_IDENTITY: begin
                rdMux[`SPIE_ID_PENDN] = pendingN_r;
                rdMux[`SPIE_ID_CODE_HI:`SPIE_ID_CODE_LO] = srcCode_r;
            end
            `SPIE_OFS_FIFOCTL: begin
                rdMux = fifoCtl_r;
            end
            `SPIE_OFS_LINECTL: begin
                rdMux[`SPIE_LC_WLEN_HI:`SPIE_LC_WLEN_LO] = wordLen_r;
            end
            `SPIE_OFS_LINESTAT: begin
                rdMux[`SPIE_LS_AVAIL]   = rxAvail;
                rdMux[`SPIE_LS_OVERRUN] = overrun_r;
                rdMux[`SPIE_LS_PARITY]  = parity_r;
                rdMux[`SPIE_LS_FRAMING] = framing_r;
                rdMux[`SPIE_LS_BREAK]   = break_r;
                rdMux[`SPIE_LS_TXEMPTY] = txEmptyIn;
            end
            `SPIE_OFS_PWREMU: begin
                rdMux[`SPIE_PWR_PORTRSTN] = portSoftResetN_r;
            end
            default: begin
                rdMux = 8'h00;
            end
        endcase
    end

    // Data is held only in the cycle after the strobe; otherwise zero.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= rdMux;
        end else begin
            regRdata <= 8'h00;
        end
    end

endmodule : spie_top

`default_nettype wire

// File: verification/spie_checker.sv
// Port-level assertions for the serial-port event logic.
`default_nettype none

module spie_checker
    import spie_pkg::*;
#(
    parameter int LEVEL_W = 5
) (
    input wire logic               sys_clk,    // Clock
    input wire logic               reset,      // Reset
    input wire logic [2:0]         regAddr,    // Address
    input wire logic [7:0]         regWdata,   // Write data
    input wire logic               regWrite,   // Write strobe
    input wire logic               regRead,    // Read strobe
    input wire logic [7:0]         regRdata,   // Read data
    input wire logic               txEmptyIn,  // Transmit empty
    input wire logic [LEVEL_W-1:0] rxLevel,    // Receive level
    input wire logic               parityEvt,  // Parity error
    input wire logic               cpuIrq,     // Interrupt line
    input wire logic               rxDmaEvent, // Receive event
    input wire logic               txDmaEvent, // Transmit event
    input wire logic               portResetN  // Port reset, low active
);
    timeunit 1ns;
    timeprecision 100ps;

    // Shadow copies of the enables and FIFO mode, as software wrote them.
    logic [3:0] en_r;
    logic       fifo_r;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            en_r   <= 4'h0;
            fifo_r <= 1'b0;
        end else if (regWrite && regAddr == 3'h0) begin
            en_r <= regWdata[3:0];
        end else if (regWrite && regAddr == 3'h2) begin
            fifo_r <= regWdata[0];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_irq_needs_enable: assert property (
        $past(en_r) == 4'h0 |-> !cpuIrq) else $error("interrupt with all enables off");
    a_ls_irq_raise: assert property (
        parityEvt && en_r[2] ##1 en_r[2] |=> cpuIrq) else $error("line error not raised");
    a_avail_level: assert property (
        regRead && regAddr == 3'h4 |=> regRdata[0] == ($past(rxLevel) != '0))
        else $error("data-available bit wrong");
    a_txempty_status: assert property (
        regRead && regAddr == 3'h4 |=> regRdata[5] == $past(txEmptyIn))
        else $error("transmit-empty bit wrong");
    a_dma_fifo_only: assert property (
        !$past(fifo_r) && !$past(fifo_r, 2) |-> !rxDmaEvent && !txDmaEvent)
        else $error("DMA event outside FIFO mode");
    a_release_tx_event: assert property (
        regWrite && regAddr == 3'h5 && regWdata[0] && !portResetN && fifo_r
        |=> txDmaEvent && portResetN) else $error("no event on port release");
    a_tx_empty_event: assert property (
        fifo_r && portResetN && $rose(txEmptyIn) |=> ##[0:1] txDmaEvent)
        else $error("no event when transmit side empties");
    a_rx_event_pulse: assert property (
        rxDmaEvent |=> !rxDmaEvent) else $error("receive event longer than one cycle");

    c_rx_event: cover property (rxDmaEvent);
    c_tx_event: cover property (txDmaEvent);
    c_irq_on: cover property (cpuIrq && en_r[2]);
endmodule : spie_checker

bind spie_top spie_checker #(.LEVEL_W(LEVEL_W)) u_chk (.sys_clk, .reset, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .txEmptyIn, .rxLevel, .parityEvt,
    .cpuIrq, .rxDmaEvent, .txDmaEvent, .portResetN);

`default_nettype wire

// File: verification/spie_dma_cpu_model.sv
// DMA controller side: counts the synchronisation events of the port.
`default_nettype none

module spie_dma_cpu_model (
    input  wire logic        sys_clk,    // Clock
    input  wire logic        reset,      // Reset
    input  wire logic        rxDmaEvent, // Receive event
    input  wire logic        txDmaEvent, // Transmit event
    output var  logic [31:0] nRx,        // Receive events taken
    output var  logic [31:0] nTx         // Transmit events taken
);
    timeunit 1ns;
    timeprecision 100ps;

    // Both channels stay enabled, so no event is ever missed.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            nRx <= '0;
            nTx <= '0;
        end else begin
            nRx <= nRx + 32'(rxDmaEvent);
            nTx <= nTx + 32'(txDmaEvent);
        end
    end
endmodule : spie_dma_cpu_model

`default_nettype wire

// File: verification/spie_top_tb.sv
// Self-checking bench for the serial-port event logic.
`default_nettype none

module spie_top_tb
    import spie_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk = 0, reset = 1, regWrite = 0, regRead = 0;
    logic [2:0]  regAddr = '0;
    logic [7:0]  regWdata = '0, regRdata;
    logic [4:0]  rxLevel = '0;
    logic        txEmptyIn = 0, txLoad = 0, rxPush = 0, rxPop = 0, bclkTick = 0;
    logic        overrunEvt = 0, parityEvt = 0, framingEvt = 0, breakEvt = 0;
    logic        cpuIrq, rxDmaEvent, txDmaEvent, portResetN;
    logic [31:0] nRx, nTx;
    logic [4:0]  trigLvls [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    int          failures = 0, n_compared = 0, cyc = 0;

    spie_top #(.LEVEL_W(5)) dut (.sys_clk, .reset, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .txEmptyIn, .txLoad, .rxLevel, .rxPush, .rxPop, .overrunEvt,
        .parityEvt, .framingEvt, .breakEvt, .bclkTick, .cpuIrq, .rxDmaEvent, .txDmaEvent,
        .portResetN);
    spie_dma_cpu_model u_far (.sys_clk, .reset, .rxDmaEvent, .txDmaEvent, .nRx, .nTx);

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // The run is about 5300 cycles; this only catches a hang.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    // Outputs are read right at an edge, before that edge's updates land.
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wt(int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt

    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(logic [2:0] a, logic [7:0] e);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(posedge sys_clk);
        chk(regRdata, e);
    endtask : rd

    task automatic lineErr(logic [3:0] v);
        @(posedge sys_clk);
        {breakEvt, framingEvt, parityEvt, overrunEvt} <= v;
        @(posedge sys_clk);
        {breakEvt, framingEvt, parityEvt, overrunEvt} <= 4'h0;
    endtask : lineErr

    task automatic tick(int n);
        repeat (n) begin
            @(posedge sys_clk);
            bclkTick <= 1'b1;
            @(posedge sys_clk);
            bclkTick <= 1'b0;
        end
    endtask : tick

    initial begin
        wt(20);
        reset <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h1, 8'h01);
        chk(portResetN, 1'b0);
        for (int e = 0; e < 2; e++) begin
            wr(3'h0, e ? 8'h04 : 8'h00);
            for (int i = 0; i < 4; i++) begin
                lineErr(4'h1 << i);
                wt(3);
                chk(cpuIrq, e);
                rd(3'h1, e ? 8'h06 : 8'h01);
                rd(3'h4, 8'h02 << i);
                rd(3'h4, 8'h00);
                rd(3'h1, 8'h01);
            end
        end
        wr(3'h0, 8'h0f);
        wr(3'h5, 8'h01);
        lineErr(4'h1);
        rxLevel <= 5'd1;
        wt(3);
        rd(3'h1, 8'h06);
        rd(3'h4, 8'h03);
        rd(3'h1, 8'h00);
        txEmptyIn <= 1'b1;
        wt(2);
        rd(3'h1, 8'h02);
        lineErr(4'h4);
        wt(3);
        rd(3'h1, 8'h06);
        rd(3'h4, 8'h29);
        txLoad <= 1'b1;
        txEmptyIn <= 1'b0;
        wt(1);
        txLoad <= 1'b0;
        wt(2);
        rd(3'h1, 8'h00);
        rxLevel <= 5'd0;
        wt(2);
        rd(3'h1, 8'h01);
        chk(nRx + nTx, 0);
        wr(3'h5, 8'h00);
        wr(3'h2, 8'h41);
        wr(3'h5, 8'h01);
        wt(3);
        chk(nTx, 1);
        txEmptyIn <= 1'b1;
        wt(3);
        chk(nTx, 2);
        txEmptyIn <= 1'b0;
        rxLevel <= 5'd3;
        rd(3'h4, 8'h01);
        rd(3'h1, 8'h01);
        rxLevel <= 5'd4;
        wt(3);
        chk(nRx, 1);
        rd(3'h1, 8'h04);
        rxLevel <= 5'd3;
        rd(3'h1, 8'h01);
        for (int w = 0; w < 4; w++) begin
            wr(3'h3, 8'(w));
            rxPush <= 1'b1;
            wt(1);
            rxPush <= 1'b0;
            tick(64 * (8 + w) - 1);
            wt(4);
            rd(3'h1, 8'h01);
            tick(1);
            wt(4);
            rd(3'h1, 8'h0c);
            chk(nRx, 2 + w);
            rxPop <= 1'b1;
            wt(1);
            rxPop <= 1'b0;
            wt(3);
            rd(3'h1, 8'h01);
        end
        for (int t = 0; t < 4; t++) begin
            rxLevel <= 5'h00;
            wr(3'h2, {2'(t), 6'h01});
            rxLevel <= trigLvls[t] - 5'h01;
            wt(2);
            rd(3'h1, 8'h01);
            rxLevel <= trigLvls[t];
            wt(3);
            chk(nRx, 6 + t);
            rd(3'h1, 8'h04);
        end
        wr(3'h2, 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
        rd(3'h2, 8'h00);
        tally_and_finish();
    end
endmodule : spie_top_tb

`default_nettype wire
